// ### logic/ucgf_pkg.sv
// Package for the serial transceiver clock generator and framing block.
// Assumes a single 100 MHz system clock and an APB register bus.
package ucgf_pkg;

  // Bus widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] ADDR_DATA    = 8'h00;
  localparam logic [7:0] ADDR_STAT    = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_BAUD_LO = 8'h0C;
  localparam logic [7:0] ADDR_BAUD_HI = 8'h10;

  // Field positions in the control register.
  localparam int CTRL_W    = 10;
  localparam int CTL_SYNC  = 0;
  localparam int CTL_POL   = 1;
  localparam int CTL_PAR   = 2;
  localparam int CTL_STOP2 = 4;
  localparam int CTL_SIZE  = 5;
  localparam int CTL_CKDIR = 8;
  localparam int CTL_TX9   = 9;

  // Field positions in the status register.
  localparam int ST_U2X  = 0;
  localparam int ST_FE   = 1;
  localparam int ST_DOR  = 2;
  localparam int ST_PE   = 3;
  localparam int ST_RX9  = 4;
  localparam int ST_RXC  = 5;
  localparam int ST_TXE  = 6;
  localparam int ST_BUSY = 7;

  // Reset values: eight data bits, no parity, one stop bit.
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h060;
  localparam logic [12:0]       TXSH_RST = 13'h1FFF;

  // Ticks per bit minus one, the nine-bit size code and data bit counts.
  localparam logic [3:0] DIV_NORMAL_M1 = 4'hF;
  localparam logic [3:0] DIV_DOUBLE_M1 = 4'h7;
  localparam logic [2:0] SIZE_NINE     = 3'h7;
  localparam logic [3:0] BITS_NINE     = 4'h9;
  localparam logic [3:0] BITS_EIGHT    = 4'h8;
  localparam logic [3:0] BITS_BASE     = 4'h5;

  // Receiver state.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} ucgf_rx_e;

  // One receive FIFO entry with its own status.
  typedef struct packed {
    logic [8:0] data;
    logic       fe;
    logic       overrun_flag;
    logic       pe;
  } ucgf_rx_entry_s;

  // Whole state of the block.
  typedef struct packed {
    logic [CTRL_W-1:0]    ctrl;
    logic                 dbl;
    logic [11:0]          baud;
    logic [11:0]          bcnt;
    logic [3:0]           txpre;
    logic                 transfer_clock_pin;
    logic [2:0]           xsync;
    logic [1:0]           rxsync;
    logic [7:0]           txbuf;
    logic                 tx9buf;
    logic                 txfull;
    logic [12:0]          txsh;
    logic [3:0]           txleft;
    ucgf_rx_e             rxst;
    logic [3:0]           rxph;
    logic [3:0]           rxidx;
    logic [8:0]           rxsh;
    logic                 rxpar;
    logic                 held;
    ucgf_rx_entry_s       held_e;
    logic                 ovr;
    ucgf_rx_entry_s [1:0] fifo;
    logic                 wp;
    logic                 rp;
    logic [1:0]           cnt;
    logic [DATA_W-1:0]    prdata;
    logic                 pslverr;
  } ucgf_state_s;

endpackage

// ### logic/ucgf_top.sv
// Serial transceiver core: baud generator, clock modes, framing, buffers.
// Assumes an APB master on MCLK and asynchronous serial pins.
`timescale 1ns/10ps
module ucgf_top (
  input  wire logic                         MCLK,
  input  wire logic                         RST_N,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [ucgf_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [ucgf_pkg::DATA_W-1:0]  PWDATA,
  output wire logic [ucgf_pkg::DATA_W-1:0]  PRDATA,
  output wire logic                         PREADY,
  output wire logic                         PSLVERR,
  output wire logic                         TXD,
  input  wire logic                         RXD,
  input  wire logic                         XCK_I,
  output wire logic                         XCK_O,
  output wire logic                         XCK_OE
);
  import ucgf_pkg::*;

  // Registered state and its next value.
  ucgf_state_s    st_r;
  ucgf_state_s    st_nxt;

  // Bus decode strobes.
  logic           wr_en;
  logic           rd_en;
  logic           wr_lo;
  // Clock mode decode.
  logic           sync;
  logic           master;
  logic           slave;
  logic           dbl_eff;
  logic           pol;
  // Timing events.
  logic           tick;
  logic           rise;
  logic           fall;
  logic           chg_ev;
  logic           samp_ev;
  logic           async_bit;
  logic           tx_bit_ev;
  logic [3:0]     div_m1;
  // Frame format.
  logic [3:0]     nbits;
  logic           par_en;
  logic [16:0]    frame;
  // Receive path.
  logic           rx_bit;
  logic           samp_bit;
  logic           start_det;
  logic           rx_done;
  logic           pop;
  logic           push_en;
  logic [1:0]     cnt_pop;
  ucgf_rx_entry_s rx_e;
  ucgf_rx_entry_s push_e;
  ucgf_rx_entry_s head;

  // Maps the size code to a data bit count.
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    if (code == SIZE_NINE) begin
      return BITS_NINE;
    end else if (code[2] == 1'b0) begin
      return BITS_BASE + {2'b00, code[1:0]};
    end
    return BITS_EIGHT;
  endfunction

  // Builds a frame, LSB first, with length in the top four bits.
  function automatic logic [16:0] build_frame(input logic [8:0] d,
                                              input logic [3:0] n,
                                              input logic [1:0] pm,
                                              input logic       two);
    logic [12:0] f;
    logic        p;
    logic [3:0]  pos;
    f    = TXSH_RST;
    f[0] = 1'b0;
    p    = pm[0];
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        f[i+1] = d[i];
        p      = p ^ d[i];
      end
    end
    pos = n + 4'd1;
    if (pm[1]) begin
      f[pos] = p;
      pos    = pos + 4'd1;
    end
    pos = pos + (two ? 4'd2 : 4'd1);
    return {pos, f};
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    st_nxt    = st_r;
    wr_en     = PSEL & PENABLE & PWRITE;
    rd_en     = PSEL & PENABLE & ~PWRITE;
    wr_lo     = wr_en & (PADDR == ADDR_BAUD_LO);
    sync      = st_r.ctrl[CTL_SYNC];
    master    = sync & st_r.ctrl[CTL_CKDIR];
    slave     = sync & ~st_r.ctrl[CTL_CKDIR];
    dbl_eff   = st_r.dbl & ~sync;
    pol       = st_r.ctrl[CTL_POL];
    div_m1    = dbl_eff ? DIV_DOUBLE_M1 : DIV_NORMAL_M1;
    nbits     = char_bits(st_r.ctrl[CTL_SIZE+:3]);
    par_en    = st_r.ctrl[CTL_PAR+1];
    frame     = '0;
    async_bit = 1'b0;
    start_det = 1'b0;
    rx_done   = 1'b0;
    push_en   = 1'b0;
    push_e    = '0;
    rx_e      = '0;
    head      = st_r.fifo[st_r.rp];

    // Two-stage synchronisers for the clock and data pins.
    st_nxt.xsync  = {st_r.xsync[1:0], XCK_I};
    st_nxt.rxsync = {st_r.rxsync[0], RXD};
    rx_bit        = st_r.rxsync[1];

    // Control and divisor writes.
    if (wr_en) begin
      case (PADDR)
        ADDR_STAT: begin
          st_nxt.dbl = PWDATA[ST_U2X];
        end
        ADDR_CTRL: begin
          st_nxt.ctrl = PWDATA[CTRL_W-1:0];
        end
        ADDR_BAUD_LO: begin
          st_nxt.baud[7:0] = PWDATA[7:0];
        end
        ADDR_BAUD_HI: begin
          st_nxt.baud[11:8] = PWDATA[3:0];
        end
        default: begin
        end
      endcase
    end

    // Baud down-counter; a low write restarts it from the new value.
    tick = (st_r.bcnt == 12'h000);
    if (tick || wr_lo) begin
      st_nxt.bcnt = st_nxt.baud;
    end else begin
      st_nxt.bcnt = st_r.bcnt - 12'h001;
    end

    // Master clock toggles on each tick; it rests low otherwise.
    if (!master) begin
      st_nxt.transfer_clock_pin = 1'b0;
    end else if (tick) begin
      st_nxt.transfer_clock_pin = ~st_r.transfer_clock_pin;
    end

    // Edges come from the master toggle or the slave edge detector.
    rise = (master & tick & ~st_r.transfer_clock_pin)
         | (slave & st_r.xsync[1] & ~st_r.xsync[2]);
    fall = (master & tick & st_r.transfer_clock_pin)
         | (slave & ~st_r.xsync[1] & st_r.xsync[2]);
    // Data changes on one edge and is sampled on the other.
    chg_ev  = pol ? fall : rise;
    samp_ev = pol ? rise : fall;

    // Asynchronous transmit prescaler over 16 or 8 ticks.
    if (tick && !sync) begin
      if (st_r.txpre >= div_m1) begin
        st_nxt.txpre = 4'h0;
        async_bit    = 1'b1;
      end else begin
        st_nxt.txpre = st_r.txpre + 4'h1;
      end
    end
    tx_bit_ev = sync ? chg_ev : async_bit;

    // Transmit shifter; the buffer reloads it right after the last bit.
    if (tx_bit_ev) begin
      if (st_r.txleft > 4'h1) begin
        st_nxt.txsh   = {1'b1, st_r.txsh[12:1]};
        st_nxt.txleft = st_r.txleft - 4'h1;
      end else if (st_r.txfull) begin
        frame         = build_frame({st_r.tx9buf, st_r.txbuf}, nbits,
                                    st_r.ctrl[CTL_PAR+:2], st_r.ctrl[CTL_STOP2]);
        st_nxt.txsh   = frame[12:0];
        st_nxt.txleft = frame[16:13];
        st_nxt.txfull = 1'b0;
      end else begin
        st_nxt.txsh   = TXSH_RST;
        st_nxt.txleft = 4'h0;
      end
    end

    // A data write fills the buffer after any load in this cycle.
    if (wr_en && (PADDR == ADDR_DATA)) begin
      st_nxt.txbuf  = PWDATA[7:0];
      st_nxt.tx9buf = st_r.ctrl[CTL_TX9];
      st_nxt.txfull = 1'b1;
    end

    // Receiver phase: 16 or 8 ticks async, one edge per bit sync.
    samp_bit = sync ? samp_ev : (tick && (st_r.rxph == div_m1));
    if (tick && !sync && (st_r.rxst != RX_IDLE)) begin
      st_nxt.rxph = (st_r.rxph == div_m1) ? 4'h0 : st_r.rxph + 4'h1;
    end

    // Receiver sequencing.
    case (st_r.rxst)
      RX_IDLE: begin
        if (sync ? (samp_ev && !rx_bit) : (tick && !rx_bit)) begin
          start_det    = 1'b1;
          st_nxt.rxsh  = 9'h000;
          st_nxt.rxidx = 4'h0;
          st_nxt.rxph  = 4'h0;
          st_nxt.rxst  = sync ? RX_BITS : RX_START;
        end
      end
      RX_START: begin
        // Mid-bit check rejects a false start.
        if (tick && (st_r.rxph == (div_m1 >> 1))) begin
          st_nxt.rxph = 4'h0;
          st_nxt.rxst = rx_bit ? RX_IDLE : RX_BITS;
        end
      end
      RX_BITS: begin
        if (samp_bit) begin
          if (st_r.rxidx < nbits) begin
            st_nxt.rxsh[st_r.rxidx] = rx_bit;
          end else begin
            st_nxt.rxpar = rx_bit;
          end
          if (st_r.rxidx == (nbits - 4'h1 + {3'b000, par_en})) begin
            st_nxt.rxst = RX_STOP;
          end else begin
            st_nxt.rxidx = st_r.rxidx + 4'h1;
          end
        end
      end
      RX_STOP: begin
        // Only the first stop bit is looked at.
        if (samp_bit) begin
          rx_done     = 1'b1;
          rx_e.data   = st_r.rxsh;
          rx_e.fe     = ~rx_bit;
          rx_e.pe     = par_en &
                        (st_r.rxpar != (^st_r.rxsh ^ st_r.ctrl[CTL_PAR]));
          st_nxt.rxst = RX_IDLE;
        end
      end
      default: begin
        st_nxt.rxst = RX_IDLE;
      end
    endcase

    // Receive FIFO: pop on a data read, then push held or new frame.
    pop = rd_en && (PADDR == ADDR_DATA) && (st_r.cnt != 2'h0);
    if (pop) begin
      st_nxt.rp = ~st_r.rp;
    end
    cnt_pop = st_r.cnt - {1'b0, pop};
    if (st_r.held && (cnt_pop < 2'h2)) begin
      push_en     = 1'b1;
      push_e      = st_r.held_e;
      st_nxt.held = 1'b0;
    end else if (rx_done) begin
      if (cnt_pop < 2'h2) begin
        push_en = 1'b1;
        push_e  = rx_e;
      end else begin
        st_nxt.held   = 1'b1;
        st_nxt.held_e = rx_e;
      end
    end
    if (push_en) begin
      push_e.overrun_flag              = st_r.ovr;
      st_nxt.fifo[st_r.wp]    = push_e;
      st_nxt.wp               = ~st_r.wp;
      st_nxt.ovr              = 1'b0;
    end
    st_nxt.cnt = cnt_pop + {1'b0, push_en};
    // A new start with a frame still held loses that frame.
    if (start_det && st_r.held && !push_en) begin
      st_nxt.held = 1'b0;
      st_nxt.ovr  = 1'b1;
    end

    // Read data and error are captured in the setup phase.
    if (PSEL && !PENABLE) begin
      st_nxt.prdata  = '0;
      st_nxt.pslverr = 1'b0;
      case (PADDR)
        ADDR_DATA: begin
          st_nxt.prdata[7:0] = (st_r.cnt != 2'h0) ? head.data[7:0] : 8'h00;
        end
        ADDR_STAT: begin
          // Status shows the entry at the FIFO head.
          st_nxt.prdata[ST_U2X]  = st_r.dbl;
          st_nxt.prdata[ST_FE]   = (st_r.cnt != 2'h0) & head.fe;
          st_nxt.prdata[ST_DOR]  = (st_r.cnt != 2'h0) & head.overrun_flag;
          st_nxt.prdata[ST_PE]   = (st_r.cnt != 2'h0) & head.pe;
          st_nxt.prdata[ST_RX9]  = (st_r.cnt != 2'h0) & head.data[8];
          st_nxt.prdata[ST_RXC]  = (st_r.cnt != 2'h0);
          st_nxt.prdata[ST_TXE]  = ~st_r.txfull;
          st_nxt.prdata[ST_BUSY] = (st_r.txleft != 4'h0);
        end
        ADDR_CTRL: begin
          st_nxt.prdata[CTRL_W-1:0] = st_r.ctrl;
        end
        ADDR_BAUD_LO: begin
          st_nxt.prdata[7:0] = st_r.baud[7:0];
        end
        ADDR_BAUD_HI: begin
          st_nxt.prdata[3:0] = st_r.baud[11:8];
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register; the line idles high out of reset.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.txsh <= TXSH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The slave always answers without wait states.
  assign PREADY  = 1'b1;
  assign PRDATA  = st_r.prdata;
  assign PSLVERR = st_r.pslverr;
  assign TXD     = st_r.txsh[0];
  assign XCK_O   = st_r.transfer_clock_pin;
  assign XCK_OE  = master;

  // Checks run on the system clock, idle in reset.
  default clocking dcb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  // Counter reloads the divisor on a tick with no low-byte write, including a high byte written in that cycle.
  chk_baud_reload: assert property (
    (tick && !wr_lo) |=> (st_r.bcnt == st_r.baud))
    else $error("baud counter did not reload");

  // Normal async bit clock falls on the sixteenth tick.
  chk_tx_rate: assert property (
    (!sync && !st_r.dbl && tx_bit_ev) |-> (tick && st_r.txpre == 4'hF))
    else $error("async bit clock off sixteen ticks");

  // Clock pin is neither driven nor toggled outside sync master.
  chk_xck_quiet: assert property (
    !master |=> !XCK_O)
    else $error("clock pin active outside master");

  // Master clock pin toggles on each tick.
  chk_xck_toggle: assert property (
    (master && tick) ##1 master |-> (XCK_O != $past(XCK_O)))
    else $error("master clock did not toggle");

  // In sync mode the line moves only on the change edge, never the sample edge.
  chk_sync_edge: assert property (
    (sync && !chg_ev) |=> $stable(TXD))
    else $error("serial data moved off its change edge");

  // Buffered data starts at once after the last bit.
  chk_tx_gap: assert property (
    (tx_bit_ev && st_r.txleft == 4'h1 && st_r.txfull) |=> !TXD [*1] ##0 st_r.txleft > 4'h1)
    else $error("gap before buffered frame");

  // Idle line stays high.
  chk_idle_high: assert property (
    (st_r.txleft == 4'h0) |-> TXD)
    else $error("idle line not high");

  // A pop with no push lowers the count by one.
  chk_fifo_pop: assert property (
    (pop && !push_en) |=> (st_r.cnt == $past(st_r.cnt) - 2'h1))
    else $error("pop did not remove one entry");

  // A start with a held frame drops it and flags overrun.
  chk_overrun: assert property (
    (start_det && st_r.held && !push_en) |=> (st_r.ovr && !st_r.held))
    else $error("overrun not flagged on new start");

endmodule

// ### test/ucgf_partner.sv
// Far-side serial model: sends and captures async and synchronous frames.
// Assumes MCLK is the device clock; it samples lines on the falling edge.
`timescale 1ns/10ps
module ucgf_partner (
  input  wire logic MCLK,
  input  wire logic TXD,
  input  wire logic XCK_O,
  output logic      RXD,
  output logic      XCK_I
);
  // The line idles high and the slave clock stands still.
  initial begin
    RXD   = 1'b1;
    XCK_I = 1'b0;
  end

  // Async capture: find the start bit, then sample each bit at its middle.
  task automatic recv(input int bc, input int nb, output logic [12:0] f, output time t);
    int n;
    f = '1;
    for (n = 0; n < 9000 && TXD !== 1'b0; n++) @(negedge MCLK);
    t = $time;
    repeat (bc / 2) @(negedge MCLK);
    for (int i = 0; i < nb; i++) begin
      f[i] = TXD;
      if (i < nb - 1) repeat (bc) @(negedge MCLK);
    end
  endtask

  // Sync capture: sample where the clock moves to the polarity level.
  task automatic srecv(input logic pol, input int nb, output logic [12:0] f);
    logic p;
    int   k;
    int   n;
    f = '1;
    k = 0;
    p = XCK_O;
    for (n = 0; n < 9000 && k < nb; n++) begin
      @(negedge MCLK);
      if (p !== pol && XCK_O === pol && (k > 0 || TXD === 1'b0)) begin
        f[k] = TXD;
        k++;
      end
      p = XCK_O;
    end
  endtask

  // Async send; the stop bits leave the line high afterwards.
  task automatic send(input int bc, input int nb, input logic [12:0] f);
    for (int i = 0; i < nb; i++) begin
      RXD <= f[i];
      repeat (bc) @(posedge MCLK);
    end
  endtask

  // Slave-clock send; a 16-cycle period keeps well below a quarter of MCLK.
  task automatic ssend(input logic pol, input int nb, input logic [12:0] f);
    XCK_I <= pol;
    repeat (8) @(posedge MCLK);
    for (int i = 0; i < nb; i++) begin
      XCK_I <= ~pol;
      RXD   <= f[i];
      repeat (8) @(posedge MCLK);
      XCK_I <= pol;
      repeat (8) @(posedge MCLK);
    end
  endtask
endmodule

// ### test/ucgf_top_tb.sv
// Testbench for the serial core: APB register tasks and frame checks.
// Assumes the far-side model ucgf_partner and a 100 MHz MCLK.
`timescale 1ns/10ps
module ucgf_top_tb;
  import ucgf_pkg::*;
  logic              MCLK, RST_N, PSEL, PENABLE, PWRITE;
  logic [ADDR_W-1:0] PADDR;
  logic [DATA_W-1:0] PWDATA, PRDATA;
  logic              PREADY, PSLVERR, TXD, RXD, XCK_I, XCK_O, XCK_OE;
  int                failures, comparisons;

  ucgf_top dut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TXD(TXD), .RXD(RXD), .XCK_I(XCK_I), .XCK_O(XCK_O), .XCK_OE(XCK_OE));
  ucgf_partner partner (.MCLK(MCLK), .TXD(TXD), .XCK_O(XCK_O), .RXD(RXD), .XCK_I(XCK_I));

  // Free-running 100 MHz clock.
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until PREADY is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) begin
      failures++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask

  // Expected frame bits in line order: start, data LSB first, parity, stops.
  function automatic logic [12:0] mkf(input logic [8:0] d, input int n, input logic [1:0] pm);
    logic [12:0] f;
    logic        p;
    f = '1;
    f[0] = 1'b0;
    p = pm[0];
    for (int i = 0; i < n; i++) begin
      f[1 + i] = d[i];
      p = p ^ d[i];
    end
    if (pm[1]) f[1 + n] = p;
    return f;
  endfunction

  // Main sequence.
  initial begin
    logic [31:0] q;
    logic        e;
    logic [12:0] f, g;
    time         t1, t2;
    logic [2:0]  sc;
    logic [1:0]  pm;
    int          n;
    RST_N   = 1'b0;
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = '0;
    PWDATA  = '0;
    failures    = 0;
    comparisons = 0;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    // Reset values, divisor width and an unmapped address.
    rd(ADDR_CTRL, 32'h060);
    rd(ADDR_STAT, 32'h040);
    chk({31'h0, XCK_OE}, 32'h0);
    wr(ADDR_BAUD_HI, 32'hFF);
    rd(ADDR_BAUD_HI, 32'h0F);
    wr(ADDR_BAUD_LO, 32'hAB);
    rd(ADDR_BAUD_LO, 32'hAB);
    wr(ADDR_BAUD_HI, 32'h0);
    wr(ADDR_BAUD_LO, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Two buffered writes leave as frames with no gap between them.
    fork
      begin
        partner.recv(16, 10, f, t1);
        partner.recv(16, 10, g, t2);
      end
      begin
        wr(ADDR_DATA, 32'hA5);
        // Let the first byte reach the shifter so the second does not overwrite it.
        repeat (20) @(posedge MCLK);
        wr(ADDR_DATA, 32'h3C);
      end
    join
    chk(f, mkf(9'h0A5, 8, 2'b00));
    chk(g, mkf(9'h03C, 8, 2'b00));
    chk(t2 - t1, 32'd1600);
    // Frame formats: sizes 5 to 9, parity codes 00, 10 and 11, one or two stops.
    for (int i = 0; i < 5; i++) begin
      sc = (i == 4) ? 3'h7 : i[2:0];
      n  = (i == 4) ? 9 : 5 + i;
      pm = (i % 3 == 0) ? 2'b00 : {1'b1, i[0]};
      wr(ADDR_CTRL, {22'h0, 2'b10, sc, i[0], pm, 2'b00});
      fork
        partner.recv(16, 2 + n + pm[1] + i[0], f, t1);
        wr(ADDR_DATA, 32'h1A5);
      join
      chk(f, mkf(9'h1A5, n, pm));
      repeat (40) @(posedge MCLK);
      chk({31'h0, TXD}, 32'h1);
    end
    // Double speed with divisor 2: 24 cycles a bit both ways.
    wr(ADDR_CTRL, 32'h060);
    wr(ADDR_STAT, 32'h1);
    rd(ADDR_STAT, 32'h41);
    wr(ADDR_BAUD_LO, 32'h2);
    fork
      partner.recv(24, 10, f, t1);
      wr(ADDR_DATA, 32'h5A);
    join
    chk(f, mkf(9'h05A, 8, 2'b00));
    repeat (30) @(posedge MCLK);
    partner.send(24, 10, mkf(9'h0C7, 8, 2'b00));
    repeat (10) @(posedge MCLK);
    rd(ADDR_DATA, 32'hC7);
    wr(ADDR_STAT, 32'h0);
    wr(ADDR_BAUD_LO, 32'h0);
    // Four frames unread: two buffered, third held then dropped by the fourth.
    for (int i = 1; i < 5; i++) partner.send(16, 10, mkf({1'b0, i[3:0], i[3:0]}, 8, 2'b00));
    repeat (10) @(posedge MCLK);
    rd(ADDR_STAT, 32'h60);
    rd(ADDR_DATA, 32'h11);
    rd(ADDR_STAT, 32'h60);
    rd(ADDR_DATA, 32'h22);
    rd(ADDR_STAT, 32'h64);
    rd(ADDR_DATA, 32'h44);
    rd(ADDR_STAT, 32'h40);
    rd(ADDR_DATA, 32'h0);
    // Parity error, frame error and a ninth bit, each with its entry.
    wr(ADDR_CTRL, 32'h068);
    partner.send(16, 11, mkf(9'h001, 8, 2'b10) ^ 13'h200);
    repeat (10) @(posedge MCLK);
    rd(ADDR_STAT, 32'h68);
    rd(ADDR_DATA, 32'h01);
    partner.send(16, 12, mkf(9'h003, 8, 2'b10) ^ 13'h400);
    repeat (10) @(posedge MCLK);
    rd(ADDR_STAT, 32'h62);
    rd(ADDR_DATA, 32'h03);
    wr(ADDR_CTRL, 32'h0E0);
    partner.send(16, 11, mkf(9'h155, 9, 2'b00));
    repeat (10) @(posedge MCLK);
    rd(ADDR_STAT, 32'h70);
    rd(ADDR_DATA, 32'h55);
    // Sync master, both polarities; double speed stays clear here.
    wr(ADDR_BAUD_LO, 32'h1);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL, {22'h0, 2'b01, 3'h3, 3'h0, p[0], 1'b1});
      @(negedge MCLK);
      chk({31'h0, XCK_OE}, 32'h1);
      q[0] = XCK_O;
      repeat (2) @(negedge MCLK);
      chk({31'h0, XCK_O}, {31'h0, ~q[0]});
      fork
        partner.srecv(p[0], 10, f);
        wr(ADDR_DATA, 32'hC3);
      join
      chk(f, mkf(9'h0C3, 8, 2'b00));
      repeat (40) @(posedge MCLK);
    end
    // Sync slave receive, both polarities, clock from the far side.
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL, {22'h0, 2'b00, 3'h3, 3'h0, p[0], 1'b1});
      @(negedge MCLK);
      chk({31'h0, XCK_OE}, 32'h0);
      partner.ssend(p[0], 10, mkf(p ? 9'h069 : 9'h096, 8, 2'b00));
      repeat (10) @(posedge MCLK);
      rd(ADDR_STAT, 32'h60);
      rd(ADDR_DATA, p ? 32'h69 : 32'h96);
    end
    summarize();
  end
endmodule
